// ---- rtl/eac_regs.vh ----
// Register offsets, bit positions and timing constants of the nonvolatile access controller
`ifndef EAC_REGS_VH
`define EAC_REGS_VH

// I/O-space offsets (data-space address is offset plus EAC_DS_OFFSET)
`define EAC_OFF_CTRL 6'h1f
`define EAC_OFF_DATA 6'h20
`define EAC_OFF_ADDRL 6'h21
`define EAC_OFF_ADDRH 6'h22
`define EAC_DS_OFFSET 8'h20
`define EAC_IO_TOP 8'h3f
`define EAC_BITOP_TOP 6'h1f

// Control register bit positions
`define EAC_CTRL_RSTROBE 0
`define EAC_CTRL_PSTROBE 1
`define EAC_CTRL_MWE 2
`define EAC_CTRL_RIE 3
`define EAC_CTRL_PM_LO 4
`define EAC_CTRL_PM_HI 5

// Programming modes
`define EAC_PM_ATOMIC 2'h0
`define EAC_PM_ERASE 2'h1
`define EAC_PM_WRITE 2'h2
`define EAC_PM_RSVD 2'h3

// Address field
`define EAC_ADDR_W 9
`define EAC_ADDR_HI_BIT 8

// Master write enable window and CPU stall lengths, in clock cycles
`define EAC_MWE_WINDOW 3'h4
`define EAC_STALL_READ 3'h4
`define EAC_STALL_PROG 3'h2

// Programming times, timed on calibrated oscillator ticks
`define EAC_RC_KHZ 8000
`define EAC_T_ATOMIC_US 3400
`define EAC_T_HALF_US 1800
`define EAC_T_CPU_WRITE_US 3300
`define EAC_RC_CPU_WRITE_TICKS 26368
`define EAC_TICK_W 16

`endif

// ---- rtl/eac_stall.v ----
// CPU stall generator: holds the stall output for a loaded number of cycles
`timescale 1ns/100ps
module eac_stall (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire load_i,
  input wire [2:0] cycles_i,
  output wire stall_o
);
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = cycles_i;
    end else if (cnt_q != 3'h0) begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign stall_o = (cnt_q != 3'h0);
endmodule

// ---- rtl/eac_prog_timer.v ----
// Programming-time counter driven by calibrated oscillator ticks
`timescale 1ns/100ps
`include "eac_regs.vh"
module eac_prog_timer (
  input wire clk_sys_i,
  input wire por_n_i,
  input wire start_i,
  input wire [`EAC_TICK_W-1:0] ticks_i,
  input wire rc_tick_i,
  output reg done_o
);
  reg [`EAC_TICK_W-1:0] cnt_q;

  // Reset only by power-on so a running write survives a system reset
  always @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      cnt_q <= {`EAC_TICK_W{1'b0}};
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= ticks_i;
      end else if (rc_tick_i && cnt_q != {`EAC_TICK_W{1'b0}}) begin
        cnt_q <= cnt_q - {{(`EAC_TICK_W-1){1'b0}}, 1'b1};
        if (cnt_q == {{(`EAC_TICK_W-1){1'b0}}, 1'b1}) begin
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- rtl/eac_top.v ----
// Nonvolatile data memory access controller: address, data and control registers
`timescale 1ns/100ps
`include "eac_regs.vh"
module eac_top #(
  parameter [`EAC_TICK_W-1:0] PROG_ATOMIC_TICKS = `EAC_RC_CPU_WRITE_TICKS,
  parameter [`EAC_TICK_W-1:0] PROG_HALF_TICKS = `EAC_T_HALF_US * `EAC_RC_KHZ / 1000
) (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire por_n_i,
  input wire [7:0] cpu_addr_i,
  input wire cpu_io_space_i,
  input wire cpu_wr_i,
  input wire cpu_rd_i,
  input wire [7:0] cpu_wdata_i,
  input wire cpu_bit_set_i,
  input wire cpu_bit_clr_i,
  input wire [2:0] cpu_bit_sel_i,
  output wire [7:0] cpu_rdata_o,
  output wire cpu_stall_o,
  input wire global_irq_enable_i,
  input wire flash_selfprog_enable_i,
  input wire rc_tick_i,
  output wire ready_irq_o,
  output wire [`EAC_ADDR_W-1:0] arr_addr_o,
  output wire [7:0] arr_wdata_o,
  input wire [7:0] arr_rdata_i,
  output wire arr_erase_o,
  output wire arr_write_o
);

  // Turns a CPU address into an I/O offset; bit 6 flags a hit in I/O space
  function [6:0] io_decode;
    input [7:0] addr;
    input io_space;
    reg [7:0] off;
    begin
      off = io_space ? addr : addr - `EAC_DS_OFFSET;
      if (!io_space && addr < `EAC_DS_OFFSET) begin
        io_decode = 7'h00;
      end else if (off > `EAC_IO_TOP) begin
        io_decode = 7'h00;
      end else begin
        io_decode = {1'b1, off[5:0]};
      end
    end
  endfunction

  // Merges written bits into an old byte under a lane mask
  function [7:0] merge;
    input [7:0] old;
    input [7:0] val;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (val & mask);
    end
  endfunction

  wire [6:0] dec;
  wire hit;
  wire [5:0] off;
  wire bit_op;
  wire acc_wr;
  reg [7:0] wmask;
  reg [7:0] wval;
  wire [7:0] wone;
  wire wr_ctrl;
  wire wr_data;
  wire wr_addrl;
  wire wr_addrh;

  reg [`EAC_ADDR_W-1:0] addr_q;
  reg [7:0] data_q;
  reg [1:0] mode_q;
  reg pstrobe_q;
  reg rie_q;
  reg mwe_q;
  reg [2:0] mwe_cnt_q;
  reg [7:0] rdata_q;
  reg irq_q;
  reg [7:0] arr_wdata_q;
  reg arr_erase_q;
  reg arr_write_q;

  wire [7:0] ctrl_rd;
  reg [7:0] rd_mux;
  wire start_req;
  wire prog_start;
  wire read_req;
  wire prog_done;
  reg [`EAC_TICK_W-1:0] ticks;
  wire stall_load;
  wire [2:0] stall_len;

  assign dec = io_decode(cpu_addr_i, cpu_io_space_i);
  assign hit = dec[6];
  assign off = dec[5:0];
  // Bit instructions only reach the low half of I/O space
  assign bit_op = (cpu_bit_set_i | cpu_bit_clr_i) && cpu_io_space_i && off <= `EAC_BITOP_TOP;
  assign acc_wr = hit && (cpu_wr_i || bit_op);

  always @* begin
    if (cpu_wr_i) begin
      wmask = 8'hff;
      wval = cpu_wdata_i;
    end else begin
      wmask = 8'h01 << cpu_bit_sel_i;
      wval = cpu_bit_set_i ? 8'hff : 8'h00;
    end
  end

  assign wone = wmask & wval;
  assign wr_ctrl = acc_wr && off == `EAC_OFF_CTRL;
  assign wr_data = acc_wr && off == `EAC_OFF_DATA;
  assign wr_addrl = acc_wr && off == `EAC_OFF_ADDRL;
  assign wr_addrh = acc_wr && off == `EAC_OFF_ADDRH;

  // Strobe accepted only with armed enable, idle array and flash quiet
  assign start_req = wr_ctrl && wone[`EAC_CTRL_PSTROBE] && mwe_q && !pstrobe_q;
  assign prog_start = start_req && !flash_selfprog_enable_i && mode_q != `EAC_PM_RSVD;
  assign read_req = wr_ctrl && wone[`EAC_CTRL_RSTROBE] && !pstrobe_q;

  always @* begin
    case (mode_q)
      `EAC_PM_ATOMIC: ticks = PROG_ATOMIC_TICKS;
      `EAC_PM_ERASE: ticks = PROG_HALF_TICKS;
      `EAC_PM_WRITE: ticks = PROG_HALF_TICKS;
      default: ticks = {`EAC_TICK_W{1'b0}};
    endcase
  end

  eac_prog_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .por_n_i(por_n_i),
    .start_i(prog_start),
    .ticks_i(ticks),
    .rc_tick_i(rc_tick_i),
    .done_o(prog_done)
  );

  assign stall_load = prog_start || read_req;
  assign stall_len = read_req ? `EAC_STALL_READ : `EAC_STALL_PROG;

  eac_stall u_stall (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(stall_load),
    .cycles_i(stall_len),
    .stall_o(cpu_stall_o)
  );

  // Programming engine state: async reset only by power-on so a running write completes; system reset clears mode only when idle
  always @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      pstrobe_q <= 1'b0;
      mode_q <= `EAC_PM_ATOMIC;
      addr_q <= {`EAC_ADDR_W{1'b0}};
      data_q <= 8'h00;
      arr_wdata_q <= 8'h00;
      arr_erase_q <= 1'b0;
      arr_write_q <= 1'b0;
    end else begin
      if (prog_start) begin
        pstrobe_q <= 1'b1;
        arr_wdata_q <= data_q;
        arr_erase_q <= mode_q != `EAC_PM_WRITE;
        arr_write_q <= mode_q != `EAC_PM_ERASE;
      end else if (prog_done) begin
        pstrobe_q <= 1'b0;
        arr_erase_q <= 1'b0;
        arr_write_q <= 1'b0;
      end
      if (!rstn_i) begin
        if (!pstrobe_q) begin
          mode_q <= `EAC_PM_ATOMIC;
        end
      end else if (wr_ctrl && !pstrobe_q && (wmask[`EAC_CTRL_PM_HI] || wmask[`EAC_CTRL_PM_LO])) begin
        // Bit operations touch one mode bit only, so merge under the lane mask
        mode_q <= (mode_q & ~wmask[`EAC_CTRL_PM_HI:`EAC_CTRL_PM_LO]) |
                  (wval[`EAC_CTRL_PM_HI:`EAC_CTRL_PM_LO] & wmask[`EAC_CTRL_PM_HI:`EAC_CTRL_PM_LO]);
      end
      // Address frozen while a write runs
      if (rstn_i && !pstrobe_q) begin
        if (wr_addrl) begin
          addr_q[7:0] <= merge(addr_q[7:0], wval, wmask);
        end
        if (wr_addrh && wmask[0]) begin
          addr_q[`EAC_ADDR_HI_BIT] <= wval[0];
        end
      end
      if (rstn_i) begin
        if (read_req) begin
          data_q <= arr_rdata_i;
        end else if (wr_data) begin
          data_q <= merge(data_q, wval, wmask);
        end
      end
    end
  end

  // Master enable window: open for four cycles after software sets it
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mwe_q <= 1'b0;
      mwe_cnt_q <= 3'h0;
      rie_q <= 1'b0;
    end else begin
      if (wr_ctrl && wone[`EAC_CTRL_MWE]) begin
        mwe_q <= 1'b1;
        mwe_cnt_q <= 3'h0;
      end else if (mwe_q) begin
        if (mwe_cnt_q == `EAC_MWE_WINDOW - 3'h1) begin
          mwe_q <= 1'b0;
          mwe_cnt_q <= 3'h0;
        end else begin
          mwe_cnt_q <= mwe_cnt_q + 3'h1;
        end
      end
      if (wr_ctrl && wmask[`EAC_CTRL_RIE]) begin
        rie_q <= wval[`EAC_CTRL_RIE];
      end
    end
  end

  // Read strobe is a one-shot and always reads back zero
  assign ctrl_rd = {2'b00, mode_q, rie_q, mwe_q, pstrobe_q, 1'b0};

  always @* begin
    case (off)
      `EAC_OFF_CTRL: rd_mux = ctrl_rd;
      `EAC_OFF_DATA: rd_mux = data_q;
      `EAC_OFF_ADDRL: rd_mux = addr_q[7:0];
      `EAC_OFF_ADDRH: rd_mux = {7'h00, addr_q[`EAC_ADDR_HI_BIT]};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      if (cpu_rd_i) begin
        rdata_q <= hit ? rd_mux : 8'h00;
      end
      // Level request, dropped during a write or flash self-programming
      irq_q <= rie_q && global_irq_enable_i && !pstrobe_q && !flash_selfprog_enable_i;
    end
  end

  assign cpu_rdata_o = rdata_q;
  assign ready_irq_o = irq_q;
  assign arr_addr_o = addr_q;
  assign arr_wdata_o = arr_wdata_q;
  assign arr_erase_o = arr_erase_q;
  assign arr_write_o = arr_write_q;

endmodule

// ---- verif/eac_top_sva.sv ----
// Port-level checker for the nonvolatile access controller
`timescale 1ns/100ps
module eac_top_sva (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire por_n_i,
  input wire [7:0] cpu_addr_i,
  input wire cpu_io_space_i,
  input wire cpu_wr_i,
  input wire cpu_rd_i,
  input wire [7:0] cpu_wdata_i,
  input wire cpu_bit_set_i,
  input wire [2:0] cpu_bit_sel_i,
  input wire [7:0] cpu_rdata_o,
  input wire cpu_stall_o,
  input wire global_irq_enable_i,
  input wire flash_selfprog_enable_i,
  input wire ready_irq_o,
  input wire [8:0] arr_addr_o,
  input wire [7:0] arr_wdata_o,
  input wire arr_erase_o,
  input wire arr_write_o
);
  wire [7:0] off = cpu_io_space_i ? cpu_addr_i : cpu_addr_i - 8'h20;
  wire ctl = off == 8'h1f;
  wire busy = arr_erase_o | arr_write_o;
  wire arm = ctl & (cpu_wr_i ? cpu_wdata_i[2] : cpu_bit_set_i & cpu_io_space_i & cpu_bit_sel_i == 3'h2);
  // Age of the last arming write; saturates so a stale arm never looks fresh
  reg [2:0] age_q;
  always @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) age_q <= 3'h7;
    else if (arm) age_q <= 3'h1;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i || !por_n_i);
  sequence s_stall4; cpu_stall_o [*4] ##1 !cpu_stall_o; endsequence
  sequence s_stall2; cpu_stall_o [*2] ##1 !cpu_stall_o; endsequence
  a_read_stall: assert property (cpu_wr_i && ctl && cpu_wdata_i[1:0] == 2'h1 && !busy |=> s_stall4)
    else $error("read stall length wrong");
  a_prog_stall: assert property ($rose(busy) |-> s_stall2)
    else $error("program stall length wrong");
  a_mwe_window: assert property ($rose(busy) |-> age_q >= 3'h2 && age_q <= 3'h5)
    else $error("programming started outside enable window");
  a_no_flash_prog: assert property ($rose(busy) |-> !$past(flash_selfprog_enable_i))
    else $error("programming started during flash write");
  a_irq_cause: assert property (ready_irq_o |-> $past(global_irq_enable_i && !flash_selfprog_enable_i && !busy))
    else $error("ready request without cause");
  a_addr_frozen: assert property (busy && $past(busy) |-> $stable(arr_addr_o) && $stable(arr_wdata_o))
    else $error("array address or data moved while busy");
  a_ctrl_resv: assert property ($past(cpu_rd_i && ctl) |-> cpu_rdata_o[7:6] == 2'h0 && !cpu_rdata_o[0])
    else $error("control reserved bits not zero");
  a_addrh_resv: assert property ($past(cpu_rd_i && off == 8'h22) |-> cpu_rdata_o[7:1] == 7'h00)
    else $error("address high reserved bits not zero");
endmodule
bind eac_top eac_top_sva u_sva (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .por_n_i(por_n_i),
  .cpu_addr_i(cpu_addr_i), .cpu_io_space_i(cpu_io_space_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
  .cpu_wdata_i(cpu_wdata_i), .cpu_bit_set_i(cpu_bit_set_i), .cpu_bit_sel_i(cpu_bit_sel_i),
  .cpu_rdata_o(cpu_rdata_o), .cpu_stall_o(cpu_stall_o), .global_irq_enable_i(global_irq_enable_i),
  .flash_selfprog_enable_i(flash_selfprog_enable_i), .ready_irq_o(ready_irq_o), .arr_addr_o(arr_addr_o),
  .arr_wdata_o(arr_wdata_o), .arr_erase_o(arr_erase_o), .arr_write_o(arr_write_o));

// ---- verif/tb.sv ----
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  // Short programming times keep the run brief
  localparam [15:0] ATOM = 16'h14;
  localparam [15:0] HALF = 16'h0a;
  reg clk_sys_i = 1'b0, rstn_i = 1'b0, por_n_i = 1'b0, cpu_io_space_i = 1'b1, cpu_wr_i = 1'b0;
  reg cpu_rd_i = 1'b0, cpu_bit_set_i = 1'b0, global_irq_enable_i = 1'b1, flash_selfprog_enable_i = 1'b0;
  reg rc_tick_i = 1'b0, rd_d = 1'b0;
  reg [7:0] cpu_addr_i = 8'h00, cpu_wdata_i = 8'h00, arr_rdata_i = 8'h00, tk = 8'h00;
  reg [2:0] cpu_bit_sel_i = 3'h0;
  wire [7:0] cpu_rdata_o, arr_wdata_o;
  wire [8:0] arr_addr_o;
  wire cpu_stall_o, ready_irq_o, arr_erase_o, arr_write_o;
  integer err_count = 0, checks_done = 0, seed = 39652, cyc = 0, n, t, i;
  reg [7:0] q[$];
  reg [8:0] a;
  reg [7:0] d, e, ev;
  eac_top #(.PROG_ATOMIC_TICKS(ATOM), .PROG_HALF_TICKS(HALF)) u_eac_top (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .por_n_i(por_n_i), .cpu_addr_i(cpu_addr_i), .cpu_io_space_i(cpu_io_space_i),
    .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i), .cpu_bit_set_i(cpu_bit_set_i),
    .cpu_bit_clr_i(1'b0), .cpu_bit_sel_i(cpu_bit_sel_i), .cpu_rdata_o(cpu_rdata_o), .cpu_stall_o(cpu_stall_o),
    .global_irq_enable_i(global_irq_enable_i), .flash_selfprog_enable_i(flash_selfprog_enable_i),
    .rc_tick_i(rc_tick_i), .ready_irq_o(ready_irq_o), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
    .arr_rdata_i(arr_rdata_i), .arr_erase_o(arr_erase_o), .arr_write_o(arr_write_o));
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rc_tick_i <= ~rc_tick_i;
  always @(posedge clk_sys_i) rd_d <= cpu_rd_i;
  always @(posedge clk_sys_i) if (arr_erase_o | arr_write_o) tk <= tk + rc_tick_i;
  always @(negedge clk_sys_i) if (rd_d) begin
    ev = q.pop_front();
    `CHK("rdata", ev, cpu_rdata_o)
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Kind 0 writes a byte, 1 reads, 2 sets the bit named by the low data bits
  task bus(input [1:0] k, input [7:0] ad, input [7:0] wd);
    @(posedge clk_sys_i);
    cpu_addr_i <= ad;
    cpu_wdata_i <= wd;
    cpu_bit_sel_i <= wd[2:0];
    cpu_wr_i <= k == 2'h0;
    cpu_rd_i <= k == 2'h1;
    cpu_bit_set_i <= k == 2'h2;
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b0;
    cpu_rd_i <= 1'b0;
    cpu_bit_set_i <= 1'b0;
  endtask
  task rd(input [7:0] ad, input [7:0] ex);
    q.push_back(ex);
    bus(2'h1, ad, 8'h00);
  endtask
  task noprog(input integer w);
    bus(2'h0, 8'h1f, 8'h04);
    repeat (w) @(posedge clk_sys_i);
    bus(2'h2, 8'h1f, 8'h01);
    repeat (2) @(negedge clk_sys_i);
    `CHK("no_start", 1'b0, arr_erase_o | arr_write_o)
  endtask
  task prog(input [1:0] m, input r);
    d = 8'($random(seed));
    t = (m == 2'h0) ? ATOM : HALF;
    tk = 8'h00;
    global_irq_enable_i <= 1'b0;
    bus(2'h0, 8'h20, d);
    bus(2'h0, 8'h1f, {2'h0, m, 4'hc});
    bus(2'h2, 8'h1f, 8'h01);
    if (r) begin
      rstn_i <= 1'b0;
      @(posedge clk_sys_i);
      rstn_i <= 1'b1;
    end
    repeat (2) @(negedge clk_sys_i);
    `CHK("arr_mode", (m == 2'h3) ? 2'h0 : ~m, {arr_erase_o, arr_write_o})
    if (m == 2'h3) begin
      global_irq_enable_i <= 1'b1;
      rd(8'h1f, 8'h38);
    end else begin
      `CHK("arr_data", d, arr_wdata_o)
      bus(2'h0, 8'h21, ~a[7:0]);
      bus(2'h0, 8'h1f, {2'h0, ~m, 4'ha});
      rd(8'h1f, {2'h0, m, 4'ha});
      `CHK("arr_addr", a, arr_addr_o)
      for (n = 0; n < 200 && (arr_erase_o | arr_write_o); n++) @(posedge clk_sys_i);
      `CHK("ticks", 1'b1, tk + 1 >= t && tk <= t + 2)
      global_irq_enable_i <= 1'b1;
      repeat (2) @(negedge clk_sys_i);
      `CHK("irq", 1'b1, ready_irq_o)
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    por_n_i <= 1'b1;
    a = 9'($random(seed));
    e = 8'($random(seed));
    arr_rdata_i <= e;
    bus(2'h0, 8'h21, a[7:0]);
    bus(2'h0, 8'h22, {7'h00, a[8]});
    rd(8'h22, {7'h00, a[8]});
    rd(8'h21, a[7:0]);
    bus(2'h0, 8'h1f, 8'h01);
    repeat (4) @(posedge clk_sys_i);
    rd(8'h20, e);
    cpu_io_space_i <= 1'b0;
    rd(8'h40, e);
    cpu_io_space_i <= 1'b1;
    rd(8'h23, 8'h00);
    $display("register test done");
    for (i = 3; i >= 0; i--) prog(i[1:0], 1'b0);
    $display("mode test done");
    noprog(6);
    flash_selfprog_enable_i <= 1'b1;
    noprog(0);
    flash_selfprog_enable_i <= 1'b0;
    prog(2'h0, 1'b1);
    bus(2'h0, 8'h1f, 8'h20);
    rstn_i <= 1'b0;
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(8'h1f, 8'h00);
    $display("interlock and reset test done");
    final_report;
  end
endmodule
